// ---- core/ipo_pkg.sv ----
// image port output: shared constants, register map and types
// assumes a single pclk domain and an apb register slave in the top module
package ipo_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_POL = 8'h04;
   localparam logic [7:0] ADDR_FUNC = 8'h08;
   localparam logic [7:0] ADDR_LIMIT = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam int CTRL_EMBED = 0;
   localparam int CTRL_WIDE = 1;
   localparam int CTRL_SWAP = 2;
   localparam int CTRL_PE = 4;
   localparam int CTRL_CKS = 6;
   localparam int CTRL_GATED = 8;
   localparam int CTRL_CLAMP = 9;
   localparam int POL_QUAL = 0;
   localparam int POL_HREF = 1;
   localparam int POL_VREF = 2;
   localparam int POL_FLAG_B = 3;
   localparam int POL_FLAG_A = 4;
   localparam int FUNC_HREF = 0;
   localparam int FUNC_VREF = 2;
   localparam int FUNC_FLAG_B = 4;
   localparam int FUNC_FLAG_A = 7;
   localparam logic [31:0] CTRL_MASK = 32'h0000_03ff;
   localparam logic [31:0] POL_MASK = 32'h0000_001f;
   localparam logic [31:0] FUNC_MASK = 32'h0000_03ff;
   localparam logic [31:0] LIMIT_MASK = 32'h0000_ffff;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] POL_RST = 32'h0000_0000;
   localparam logic [31:0] FUNC_RST = 32'h0000_0000;
   localparam logic [31:0] LIMIT_RST = 32'h0000_eb10;
   localparam logic [7:0] CODE_INVALID = 8'h00;
   localparam logic [7:0] CODE_FULL = 8'hff;
   localparam logic [7:0] SUPP_LOW = 8'h01;
   localparam logic [7:0] SUPP_HIGH = 8'hfe;
   localparam logic [7:0] RECODE_LOW = 8'h03;
   localparam logic [7:0] RECODE_HIGH = 8'hfc;
   localparam logic [1:0] PE_OFF = 2'h0;
   localparam logic [1:0] PE_ON = 2'h1;
   localparam logic [1:0] PE_TRI_LOW = 2'h2;
   localparam logic [1:0] PE_TRI_HIGH = 2'h3;
   localparam logic [1:0] CKS_LLC = 2'h0;
   localparam logic [1:0] CKS_EXPANSION_INPUT_CLOCK = 2'h1;
   localparam logic [1:0] REF_GATE = 2'h0;
   localparam logic [1:0] REF_PULSE = 2'h1;
   localparam int PCLK_PERIOD_NS = 40;
   localparam int PORT_CLK_MAX_MHZ = 33;
   localparam int PORT_CLK_MIN_NS = 1000 / PORT_CLK_MAX_MHZ;
   localparam int PORT_CLK_MIN_CYC = (PORT_CLK_MIN_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
   typedef enum logic [1:0] {
      KIND_VIDEO = 2'h0,
      KIND_RAW = 2'h1,
      KIND_ANC_DIRECT = 2'h2,
      KIND_ANC_RECODE = 2'h3
   } ipo_kind_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_HDR = 4'b0010,
      ST_DATA = 4'b0100,
      ST_EAV = 4'b1000
   } ipo_state_t;
endpackage : ipo_pkg

// ---- core/ipo_fmt_if.sv ----
// image port output: carrier between the byte engine and the byte formatter
// assumes both ends live in the pclk domain; the formatter is combinational
`timescale 1ns/1ps
`default_nettype none
interface ipo_fmt_if;
   import ipo_pkg::*;
   logic [7:0] raw [2];
   logic [7:0] fmt [2];
   ipo_kind_t kind;
   logic is_code;
   logic clamp_en;
   logic [7:0] lim_lo;
   logic [7:0] lim_hi;
   modport engine (output raw, kind, is_code, clamp_en, lim_lo, lim_hi, input fmt);
   modport fmt_side (input raw, kind, is_code, clamp_en, lim_lo, lim_hi, output fmt);
endinterface : ipo_fmt_if
`default_nettype wire

// ---- core/ipo_byte_fmt.sv ----
// image port output: per-lane value suppression, clamping and recoding
// assumes lane 0 is the main lane and lane 1 the chroma extension lane
`timescale 1ns/1ps
`default_nettype none
module ipo_byte_fmt
   import ipo_pkg::*;
(
   ipo_fmt_if.fmt_side f // lane bytes in, formatted bytes out
);
   for (genvar g = 0; g < 2; g++) begin : g_lane
      always_comb begin
         logic [7:0] b;
         b = f.raw[g];
         if (!f.is_code) begin
            case (f.kind)
               KIND_VIDEO, KIND_RAW: begin
                  if (b == CODE_INVALID) b = SUPP_LOW;
                  else if (b == CODE_FULL) b = SUPP_HIGH;
                  // a low limit of 00h or a high limit of ffh is skipped; a low limit of ffh or
                  // a high limit of 00h is still applied and undoes suppression
                  if (f.clamp_en && b < f.lim_lo && f.lim_lo != CODE_INVALID) b = f.lim_lo;
                  if (f.clamp_en && b > f.lim_hi && f.lim_hi != CODE_FULL) b = f.lim_hi;
               end
               KIND_ANC_RECODE: begin
                  if (b == CODE_INVALID) b = RECODE_LOW;
                  else if (b == CODE_FULL) b = RECODE_HIGH;
               end
               default: begin
               end
            endcase
         end
         f.fmt[g] = b;
      end
   end
endmodule : ipo_byte_fmt
`default_nettype wire

// ---- core/ipo_image_port.sv ----
// image port output: serialises scaler dwords and sliced vbi lines onto the port
// assumes src_* and gates come from pclk logic; port clocks and pins are async
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ipo_image_port
   import ipo_pkg::*;
(
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic [7:0] paddr, // apb address
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb byte strobes
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic [31:0] src_data, // scaler or slicer dword
   input wire ipo_kind_t src_kind, // kind of line
   input wire logic src_last, // last dword of line
   input wire logic src_field, // field bit for codes
   input wire logic src_vblank, // vertical blanking bit for codes
   input wire logic src_valid, // dword offered
   output logic src_ready, // dword taken this cycle
   input wire logic scaler_hgate, // scaler horizontal gate
   input wire logic scaler_vgate, // scaler vertical gate
   input wire logic line_locked_clock, // decoder line clock
   input wire logic expansion_input_clock, // expansion port clock
   input wire logic port_clock_i, // port clock pin, in
   output logic port_clock_o, // port clock pin, out
   output logic port_clock_oe_n, // port clock drive enable
   input wire logic target_ready_in, // receiver ready
   input wire logic tristate_control_in, // external float control
   output logic [7:0] port_data_bus_o, // main data lane
   output logic port_data_bus_oe_n, // main lane enable
   output logic [7:0] chroma_extension_bus_o, // extension lane
   output logic chroma_extension_bus_oe_n, // extension enable
   output logic data_valid_qualifier, // qualifier or gated clock
   output logic data_valid_qualifier_oe_n, // qualifier enable
   output logic horiz_reference_out, // horizontal reference
   output logic horiz_reference_out_oe_n, // its enable
   output logic vert_reference_out, // vertical reference
   output logic vert_reference_out_oe_n, // its enable
   output logic general_flag_out_a, // flag a
   output logic general_flag_out_a_oe_n, // its enable
   output logic general_flag_out_b, // flag b
   output logic general_flag_out_b_oe_n // its enable
);
   logic [31:0] ctrl_reg, pol_reg, func_reg, limit_reg, rdata_reg;
   logic [4:0] sync1_reg, sync2_reg;
   logic clk_prev_reg, tick, clk_lvl, tgt_rdy, tri_in, port_en, wide, embed, anc_line;
   logic [1:0] swap, cks;
   ipo_state_t state_reg, state_next;
   logic [1:0] idx_reg, idx_next, lane_idx, hdr_last;
   logic have_reg, have_next, last_reg, load, emit, is_code, start;
   logic [31:0] word_reg, lane_word;
   ipo_kind_t kind_reg;
   logic field_reg, vblank_reg;
   logic [7:0] code_b, bus_reg, ext_reg;
   logic q_reg, code_reg;
   logic [1:0] gate_in, gate_prev_reg, ref_reg;
   logic [1:0] flag_reg;
   logic wr, hit;
   ipo_fmt_if fmt_bus ();

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) r[8*i +: 8] = d[8*i +: 8];
      end
      return r;
   endfunction : wmerge

   function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] sel);
      return w[8*sel +: 8];
   endfunction : pick

   // apb slave: zero wait states, read data captured in the setup phase
   assign wr = psel && penable && pwrite;
   assign hit = (paddr == ADDR_CTRL) || (paddr == ADDR_POL) || (paddr == ADDR_FUNC)
      || (paddr == ADDR_LIMIT) || (paddr == ADDR_STATUS);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata = rdata_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RST;
         pol_reg <= POL_RST;
         func_reg <= FUNC_RST;
         limit_reg <= LIMIT_RST;
      end else if (wr) begin
         case (paddr)
            ADDR_CTRL: ctrl_reg <= wmerge(ctrl_reg, pwdata, pstrb) & CTRL_MASK;
            ADDR_POL: pol_reg <= wmerge(pol_reg, pwdata, pstrb) & POL_MASK;
            ADDR_FUNC: func_reg <= wmerge(func_reg, pwdata, pstrb) & FUNC_MASK;
            ADDR_LIMIT: limit_reg <= wmerge(limit_reg, pwdata, pstrb) & LIMIT_MASK;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= 32'h0000_0000;
      end else if (psel && !penable) begin
         case (paddr)
            ADDR_CTRL: rdata_reg <= ctrl_reg;
            ADDR_POL: rdata_reg <= pol_reg;
            ADDR_FUNC: rdata_reg <= func_reg;
            ADDR_LIMIT: rdata_reg <= limit_reg;
            ADDR_STATUS: rdata_reg <= {24'h00_0000, have_reg, clk_lvl, tgt_rdy, anc_line,
                                       state_reg};
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign embed = ctrl_reg[CTRL_EMBED];
   assign wide = ctrl_reg[CTRL_WIDE];
   assign swap = ctrl_reg[CTRL_SWAP +: 2];
   assign cks = ctrl_reg[CTRL_CKS +: 2];

   // every pin input is synchronised; nothing reads sync1_reg but sync2_reg
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 5'h00;
         sync2_reg <= 5'h00;
      end else begin
         sync1_reg <= {tristate_control_in, target_ready_in, port_clock_i,
                       expansion_input_clock, line_locked_clock};
         sync2_reg <= sync1_reg;
      end
   end
   assign tgt_rdy = sync2_reg[3];
   assign tri_in = sync2_reg[4];

   // sampled clocks: port clock must stay under pclk/2, well below the 33 MHz ceiling
   always_comb begin
      case (cks)
         CKS_LLC: clk_lvl = sync2_reg[0];
         CKS_EXPANSION_INPUT_CLOCK: clk_lvl = sync2_reg[1];
         default: clk_lvl = sync2_reg[2];
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) clk_prev_reg <= 1'b0;
      else clk_prev_reg <= clk_lvl;
   end
   assign tick = clk_lvl && !clk_prev_reg;

   always_comb begin
      case (ctrl_reg[CTRL_PE +: 2])
         PE_OFF: port_en = 1'b0;
         PE_ON: port_en = 1'b1;
         PE_TRI_LOW: port_en = !tri_in;
         default: port_en = tri_in;
      endcase
   end
   assign port_clock_o = clk_lvl;
   assign port_clock_oe_n = !(port_en && !cks[1]);

   assign anc_line = kind_reg[1];
   assign hdr_last = anc_line ? 2'd2 : 2'd3;
   assign start = tick && state_reg == ST_IDLE && src_valid && tgt_rdy;

   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      have_next = have_reg;
      load = 1'b0;
      emit = 1'b0;
      is_code = 1'b0;
      code_b = CODE_INVALID;
      lane_word = word_reg;
      lane_idx = idx_reg;
      if (tick) begin
         case (state_reg)
            ST_IDLE: begin
               if (start) begin
                  state_next = embed ? ST_HDR : ST_DATA;
                  idx_next = 2'd0;
                  have_next = 1'b0;
               end
            end
            ST_HDR, ST_EAV: begin
               emit = 1'b1;
               is_code = 1'b1;
               if (anc_line) code_b = (idx_reg == 2'd0) ? CODE_INVALID : CODE_FULL;
               else if (idx_reg == 2'd0) code_b = CODE_FULL;
               else if (idx_reg != 2'd3) code_b = CODE_INVALID;
               else code_b = {1'b1, field_reg, vblank_reg, state_reg == ST_EAV,
                              vblank_reg ^ (state_reg == ST_EAV),
                              field_reg ^ (state_reg == ST_EAV), field_reg ^ vblank_reg,
                              field_reg ^ vblank_reg ^ (state_reg == ST_EAV)};
               idx_next = idx_reg + 2'd1;
               if (idx_reg == hdr_last) begin
                  idx_next = 2'd0;
                  state_next = (state_reg == ST_HDR) ? ST_DATA : ST_IDLE;
               end
            end
            ST_DATA: begin
               if (!have_reg) begin
                  // ancillary lines never pause for target ready, the slicer block is sent whole
                  if (src_valid && (tgt_rdy || anc_line)) begin
                     load = 1'b1;
                     emit = 1'b1;
                     lane_word = src_data;
                     lane_idx = 2'd0;
                     have_next = 1'b1;
                     idx_next = 2'd1;
                  end
               end else begin
                  emit = 1'b1;
                  idx_next = idx_reg + 2'd1;
                  if (idx_reg == (wide ? 2'd1 : 2'd3)) begin
                     have_next = 1'b0;
                     idx_next = 2'd0;
                     if (last_reg) state_next = (embed && !anc_line) ? ST_EAV : ST_IDLE;
                  end
               end
            end
            default: state_next = ST_IDLE;
         endcase
      end
   end
   assign src_ready = load;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         idx_reg <= 2'd0;
         have_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         have_reg <= have_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kind_reg <= KIND_VIDEO;
         field_reg <= 1'b0;
         vblank_reg <= 1'b0;
         word_reg <= 32'h0000_0000;
         last_reg <= 1'b0;
      end else begin
         if (start) begin
            kind_reg <= src_kind;
            field_reg <= src_field;
            vblank_reg <= src_vblank;
         end
         if (load) begin
            word_reg <= src_data;
            last_reg <= src_last;
         end
      end
   end

   // lane 0 main, lane 1 chroma; swap xor picks the dword byte order
   assign fmt_bus.raw[0] = pick(lane_word, wide ? {lane_idx[0], 1'b1} ^ swap
                                                : lane_idx ^ swap);
   assign fmt_bus.raw[1] = pick(lane_word, {lane_idx[0], 1'b0} ^ swap);
   assign fmt_bus.kind = kind_reg;
   assign fmt_bus.is_code = is_code;
   assign fmt_bus.clamp_en = ctrl_reg[CTRL_CLAMP];
   assign fmt_bus.lim_lo = limit_reg[7:0];
   assign fmt_bus.lim_hi = limit_reg[15:8];

   ipo_byte_fmt u_fmt (
      .f(fmt_bus.fmt_side)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_reg <= CODE_INVALID;
         ext_reg <= CODE_INVALID;
         q_reg <= 1'b0;
         code_reg <= 1'b0;
      end else if (tick) begin
         bus_reg <= !emit ? CODE_INVALID : (is_code ? code_b : fmt_bus.fmt[0]);
         ext_reg <= !(emit && wide) ? CODE_INVALID
                  : (is_code ? code_b : fmt_bus.fmt[1]);
         q_reg <= emit;
         code_reg <= emit && is_code;
      end
   end

   assign port_data_bus_o = bus_reg;
   assign chroma_extension_bus_o = ext_reg;
   assign port_data_bus_oe_n = !port_en;
   assign chroma_extension_bus_oe_n = !(port_en && wide);
   // gated clock is built from the sampled clock, so it lags the pin by the sync delay
   assign data_valid_qualifier = ctrl_reg[CTRL_GATED] ? (clk_lvl && q_reg)
                               : (q_reg ^ pol_reg[POL_QUAL]);
   assign data_valid_qualifier_oe_n = !port_en;

   assign gate_in = {scaler_vgate, scaler_hgate};
   for (genvar g = 0; g < 2; g++) begin : g_ref
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            gate_prev_reg[g] <= 1'b0;
            ref_reg[g] <= 1'b0;
         end else begin
            gate_prev_reg[g] <= gate_in[g];
            case (func_reg[2*g +: 2])
               REF_GATE: ref_reg[g] <= gate_in[g] ^ pol_reg[POL_HREF + g];
               REF_PULSE: ref_reg[g] <= (gate_in[g] && !gate_prev_reg[g])
                                        ^ pol_reg[POL_HREF + g];
               default: ref_reg[g] <= pol_reg[POL_HREF + g];
            endcase
         end
      end
   end
   assign horiz_reference_out = ref_reg[0];
   assign vert_reference_out = ref_reg[1];
   assign horiz_reference_out_oe_n = !port_en;
   assign vert_reference_out_oe_n = !port_en;

   // flag b uses index 0, flag a index 1
   for (genvar g = 0; g < 2; g++) begin : g_flag
      logic sel_src;
      always_comb begin
         case (func_reg[FUNC_FLAG_B + 3*g +: 3])
            3'h1: sel_src = anc_line && state_reg != ST_IDLE;
            3'h2: sel_src = state_reg != ST_IDLE;
            3'h3: sel_src = field_reg;
            3'h4: sel_src = vblank_reg;
            3'h5: sel_src = tgt_rdy;
            3'h6: sel_src = src_valid;
            3'h7: sel_src = q_reg;
            default: sel_src = 1'b0;
         endcase
      end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            flag_reg[g] <= 1'b0;
         end else begin
            flag_reg[g] <= sel_src ^ pol_reg[POL_FLAG_B + g];
         end
      end
   end
   assign general_flag_out_b = flag_reg[0];
   assign general_flag_out_a = flag_reg[1];
   assign general_flag_out_a_oe_n = !port_en;
   assign general_flag_out_b_oe_n = !port_en;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence code_tick_s;
      tick && (state_reg == ST_HDR || state_reg == ST_EAV);
   endsequence
   sequence href_pulse_s;
      (horiz_reference_out != pol_reg[POL_HREF]) ##1 (horiz_reference_out == pol_reg[POL_HREF]);
   endsequence

   a_invalid_zero: assert property (tick && !emit |=> !q_reg && port_data_bus_o == CODE_INVALID)
      else $error("invalid cycle without 00h");
   a_code_unbroken: assert property (code_tick_s |=> q_reg && code_reg)
      else $error("timing code cycle not valid");
   a_anc_no_gap: assert property (tick && state_reg == ST_DATA && anc_line && (have_reg || src_valid)
                                  |=> q_reg)
      else $error("gap in ancillary data");
   a_suppress_codes: assert property (q_reg && !code_reg && !kind_reg[1]
                                      |-> bus_reg != CODE_INVALID && bus_reg != CODE_FULL)
      else $error("reserved value in video");
   a_clamp_range: assert property (q_reg && !code_reg && !kind_reg[1] && ctrl_reg[CTRL_CLAMP]
                                   && limit_reg[7:0] != 8'h00 && limit_reg[15:8] != 8'hff
                                   |-> bus_reg >= limit_reg[7:0] && bus_reg <= limit_reg[15:8])
      else $error("sample outside clamp range");
   a_recode_anc: assert property (q_reg && !code_reg && kind_reg == KIND_ANC_RECODE
                                  |-> bus_reg != CODE_INVALID && bus_reg != CODE_FULL)
      else $error("unrecoded ancillary byte");
   a_ext_disabled: assert property (!wide |-> chroma_extension_bus_oe_n
                                    && ext_reg == CODE_INVALID)
      else $error("extension lane active in 8-bit mode");
   a_href_pulse: assert property (func_reg[1:0] == REF_PULSE && $stable(pol_reg)
                                  && $rose(scaler_hgate) |=> href_pulse_s)
      else $error("horizontal pulse missing");
   a_hold_not_ready: assert property (tick && state_reg == ST_IDLE && !tgt_rdy
                                      |=> state_reg == ST_IDLE && !q_reg)
      else $error("line started while not ready");
   a_gated_quiet: assert property (ctrl_reg[CTRL_GATED] && !q_reg |-> !data_valid_qualifier)
      else $error("gated clock without valid data");
   a_port_float: assert property (!port_en |-> port_data_bus_oe_n && data_valid_qualifier_oe_n
                                  && chroma_extension_bus_oe_n)
      else $error("port driven while disabled");
   a_clock_input: assert property (cks[1] |-> port_clock_oe_n)
      else $error("port clock driven in input mode");
endmodule : ipo_image_port
`default_nettype wire

// ---- tb/ipo_rx_model.sv ----
// receiving controller model: free-running port clock, random ready, byte capture
// assumes the design takes its port clock from the pin and its qualifier is active high
`timescale 1ns/1ps
`default_nettype none
module ipo_rx_model (
   output logic clk_o, // port clock pin
   output logic rdy_o, // target ready
   input wire logic [7:0] data_i, // main lane
   input wire logic qual_i // qualifier
);
   logic [7:0] got [$];
   int bad = 0;
   initial clk_o = 1'b0;
   initial rdy_o = 1'b1;
   always #160 clk_o = ~clk_o; // 320 ns, never stops
   always @(posedge clk_o) begin
      if (qual_i) got.push_back(data_i);
      else if (data_i !== 8'h00) bad++;
      rdy_o <= ($urandom % 4) != 0; // stalls a quarter of the time
   end
endmodule : ipo_rx_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// image port bench: apb setup, random lines of every kind, byte stream compare
// assumes ipo_rx_model drives the port clock pin and target ready
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin fail_count++; \
   $display("[ERR] %s exp %h seen %h", n, e, s); end end
module tb_top;
   import ipo_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic src_last = 1'b1, src_valid = 1'b0, src_field = 1'b0, src_vblank = 1'b0;
   logic tristate_control_in = 1'b0, pready, pslverr, src_ready, d_oe_n, c_oe_n;
   logic port_clock_i, target_ready_in, data_valid_qualifier;
   logic [7:0] paddr = 8'h00, port_data_bus_o, exp_q [$];
   logic [31:0] pwdata = 32'h0, src_data = 32'h0, prdata, rd, d;
   ipo_kind_t src_kind = KIND_VIDEO;
   int fail_count = 0, samples_checked = 0, cyc = 0;
   always #20 pclk = ~pclk;
   ipo_image_port i_dut (.*, .pstrb(4'hf), .scaler_hgate(1'b0), .scaler_vgate(1'b0),
      .line_locked_clock(1'b0), .expansion_input_clock(1'b0), .port_clock_o(),
      .port_clock_oe_n(), .port_data_bus_oe_n(d_oe_n), .chroma_extension_bus_o(),
      .chroma_extension_bus_oe_n(c_oe_n), .data_valid_qualifier_oe_n(),
      .horiz_reference_out(), .horiz_reference_out_oe_n(), .vert_reference_out(),
      .vert_reference_out_oe_n(), .general_flag_out_a(), .general_flag_out_a_oe_n(),
      .general_flag_out_b(), .general_flag_out_b_oe_n());
   ipo_rx_model i_rx (.clk_o(port_clock_i), .rdy_o(target_ready_in),
      .data_i(port_data_bus_o), .qual_i(data_valid_qualifier));
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge keeps a following call from reassigning psel in this time step
      @(posedge pclk);
   endtask : apb
   task automatic send(input ipo_kind_t k);
      src_valid <= 1'b1;
      src_kind <= k;
      src_data <= d;
      do @(posedge pclk); while (src_ready !== 1'b1);
      src_valid <= 1'b0;
   endtask : send
   function automatic logic [7:0] xy(input logic f, v, h);
      return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
   endfunction : xy
   function automatic logic [7:0] fix(input ipo_kind_t k, input logic [7:0] b);
      if (k == KIND_ANC_DIRECT) return b;
      if (k == KIND_ANC_RECODE) return b == 8'h00 ? 8'h03 : b == 8'hff ? 8'hfc : b;
      return b == 8'h00 ? 8'h01 : b == 8'hff ? 8'hfe : b;
   endfunction : fix
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         give_verdict();
      end
   end
   initial begin
      ipo_kind_t k;
      logic [1:0] sw;
      logic f, v;
      void'($urandom(32'h4ab2));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_LIMIT, 32'h0);
      `CHK("limit", LIMIT_RST, rd)
      apb(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 1'b1, err)
      apb(1'b1, ADDR_CTRL, 32'h0000_00b2);
      for (int t = 0; t < 2; t++) begin
         tristate_control_in <= t[0];
         repeat (4) @(posedge pclk);
         `CHK("main oe", !t[0], d_oe_n)
         `CHK("chroma oe", !t[0], c_oe_n)
      end
      for (int i = 0; i < 12; i++) begin
         k = ipo_kind_t'(i % 4);
         sw = 2'($urandom);
         {f, v} = 2'($urandom);
         d = $urandom;
         if (i < 4) d[15:0] = 16'hff00;
         apb(1'b1, ADDR_CTRL, {24'h0, 4'h9, sw, 2'h1});
         `CHK("chroma off", 1'b1, c_oe_n)
         i_rx.got.delete();
         if (k < KIND_ANC_DIRECT) exp_q = '{8'hff, 8'h00, 8'h00, xy(f, v, 1'b0)};
         else exp_q = '{8'h00, 8'hff, 8'hff};
         for (int n = 0; n < 4; n++) exp_q.push_back(fix(k, d[8 * (n ^ sw) +: 8]));
         if (k < KIND_ANC_DIRECT) exp_q = {exp_q, 8'hff, 8'h00, 8'h00, xy(f, v, 1'b1)};
         src_field <= f;
         src_vblank <= v;
         send(k);
         do apb(1'b0, ADDR_STATUS, 32'h0); while (rd[0] !== 1'b1);
         while (i_rx.got.size() < exp_q.size()) @(posedge pclk);
         foreach (exp_q[j]) `CHK("byte", exp_q[j], i_rx.got[j])
      end
      `CHK("idle bytes", 0, i_rx.bad)
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
